/* core/rlc_exec_defines.svh */
`ifndef RLC_EXEC_DEFINES_SVH
`define RLC_EXEC_DEFINES_SVH

// operand widths
`define DATA_W        8
`define FADDR_W       7
`define PC_W          15
// instruction cycle counts
`define RET_CYCLES    2
`define ROT_CYCLES    1
// reset values
`define ACC_RESET     8'h00
`define CARRY_RESET   1'b0
// destination select encodings
`define DEST_ACC      1'b0
`define DEST_FILE     1'b1

`endif

/* core/rlc_exec_pkg.sv */
`default_nettype none
package rlc_exec_pkg;
  `include "rlc_exec_defines.svh"

  typedef enum logic [1:0] {
    OP_NONE,
    OP_RET_IMM,
    OP_ROT_LEFT,
    OP_ROT_RIGHT
  } exec_op_t;

  // one issued instruction from the sequencer
  typedef struct packed {
    exec_op_t                op;
    logic [`DATA_W-1:0]      imm;
    logic [`FADDR_W-1:0]     fileAddr;
    logic                    dest;
  } exec_req_t;

  // register file write port
  typedef struct packed {
    logic                    en;
    logic [`FADDR_W-1:0]     addr;
    logic [`DATA_W-1:0]      data;
  } file_wr_t;
endpackage
`default_nettype wire

/* core/return_literal_and_carry_rotate_exec.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rlc_exec_defines.svh"

module return_literal_and_carry_rotate_exec
  import rlc_exec_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire logic                reqValid,
  input  wire exec_req_t           req,
  input  wire logic [`DATA_W-1:0]  fileRdData,
  input  wire logic [`PC_W-1:0]    stackTop,
  output var  logic [`FADDR_W-1:0] fileRdAddr,
  output var  file_wr_t            fileWr,
  output var  logic [`DATA_W-1:0]  acc,
  output var  logic                carry,
  output var  logic                stackPop,
  output var  logic                pcLoad,
  output var  logic [`PC_W-1:0]    pcNext,
  output var  logic                busy
);

  // second state is the refill bubble after a return
  typedef enum logic {ST_IDLE, ST_RET2} state_t;

  state_t                state_q;
  state_t                state_d;
  logic [`DATA_W-1:0]    acc_q;
  logic [`DATA_W-1:0]    acc_d;
  logic                  carry_q;
  logic                  carry_d;
  file_wr_t              fileWr_q;
  file_wr_t              fileWr_d;
  logic                  stackPop_q;
  logic                  pcLoad_q;
  logic [`PC_W-1:0]      pcNext_q;
  logic                  busy_q;

  // accept a new op only in idle; the sequencer must hold off during ST_RET2
  wire take      = reqValid && (state_q == ST_IDLE);
  wire isRet     = take && (req.op == OP_RET_IMM);
  wire isRotL    = take && (req.op == OP_ROT_LEFT);
  wire isRotR    = take && (req.op == OP_ROT_RIGHT);
  wire isRot     = isRotL || isRotR;

  // the file takes our registered write one edge late, so a rotate of the
  // register just written would read the old byte; bypass the pending write
  wire               fwdHit   = fileWr_q.en && (fileWr_q.addr == req.fileAddr);
  wire [`DATA_W-1:0] rotSrc   = fwdHit ? fileWr_q.data : fileRdData;

  // rotate datapath through carry, operand read combinationally
  wire [`DATA_W-1:0] rotLeft  = {rotSrc[`DATA_W-2:0], carry_q};
  wire [`DATA_W-1:0] rotRight = {carry_q, rotSrc[`DATA_W-1:1]};
  wire [`DATA_W-1:0] rotVal   = isRotL ? rotLeft : rotRight;
  wire               rotCarry = isRotL ? rotSrc[`DATA_W-1] : rotSrc[0];
  wire               toFile   = (req.dest == `DEST_FILE);

  // next state and datapath commits
  always_comb begin
    state_d  = state_q;
    acc_d    = acc_q;
    carry_d  = carry_q;
    fileWr_d = '{en: 1'b0, addr: req.fileAddr, data: rotVal};
    unique case (state_q)
      ST_IDLE: begin
        if (isRet) begin
          acc_d   = req.imm;
          state_d = ST_RET2;
        end else if (isRot) begin
          carry_d = rotCarry;
          if (toFile) begin
            fileWr_d.en = 1'b1;
          end else begin
            acc_d = rotVal;
          end
        end
      end
      ST_RET2: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state, accumulator, carry; carry never moves on a return
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= ST_IDLE;
      acc_q    <= `ACC_RESET;
      carry_q  <= `CARRY_RESET;
      fileWr_q <= '0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      acc_q    <= acc_d;
      carry_q  <= carry_d;
      fileWr_q <= fileWr_d;
      busy_q   <= (state_d == ST_RET2);
    end
  end

  // pop and reload PC one cycle after issue, in the same cycle as the refill bubble
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stackPop_q <= 1'b0;
      pcLoad_q   <= 1'b0;
      pcNext_q   <= '0;
    end else begin
      stackPop_q <= isRet;
      pcLoad_q   <= isRet;
      pcNext_q   <= isRet ? stackTop : pcNext_q;
    end
  end

  // outputs straight from their flops; the read address alone passes through
  assign fileRdAddr = req.fileAddr;
  assign fileWr     = fileWr_q;
  assign acc        = acc_q;
  assign carry      = carry_q;
  assign stackPop   = stackPop_q;
  assign pcLoad     = pcLoad_q;
  assign pcNext     = pcNext_q;
  assign busy       = busy_q;

  // assertions
  // return: taken, one bubble cycle, then free again
  sequence s_ret_issue;
    isRet;
  endsequence

  sequence s_ret_done;
    busy ##1 !busy;
  endsequence

  a_ret_acc_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRet |=> acc == $past(req.imm))
    else $error("accumulator not loaded with literal");

  a_ret_pc_pop: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRet |=> stackPop && pcLoad && pcNext == $past(stackTop))
    else $error("return did not pop stack into pc");

  a_ret_no_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRet |=> carry == $past(carry) && !fileWr.en)
    else $error("return touched carry or register file");

  a_ret_two_cycle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_ret_issue |=> s_ret_done)
    else $error("return not two cycles");

  a_rotl_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRotL |=> carry == $past(rotSrc[7])
      && (fileWr.en ? fileWr.data : acc) == {$past(rotSrc[6:0]), $past(carry)})
    else $error("rotate left result wrong");

  a_rotl_dest: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRotL && req.dest == 1'b0 |=> !fileWr.en ##0 acc == {$past(rotSrc[6:0]), $past(carry)})
    else $error("rotate left to accumulator wrote register");

  a_rotl_to_file: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRotL && req.dest == 1'b1 |=> fileWr.en && fileWr.addr == $past(req.fileAddr)
      && acc == $past(acc))
    else $error("rotate left to register wrong");

  a_rotr_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRotR |=> carry == $past(rotSrc[0])
      && (fileWr.en ? fileWr.data : acc) == {$past(carry), $past(rotSrc[7:1])})
    else $error("rotate right result wrong");

  a_rotr_to_acc: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRotR && req.dest == 1'b0 |=> !fileWr.en ##0 acc == {$past(carry), $past(rotSrc[7:1])})
    else $error("rotate right to accumulator wrote register");

  a_rotr_dest: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRotR && req.dest == 1'b1 |=> fileWr.en && fileWr.addr == $past(req.fileAddr)
      && acc == $past(acc))
    else $error("rotate right to register wrong");

  a_rot_one_cycle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRot |=> !busy)
    else $error("rotate took more than one cycle");

  // a chained rotate of the register just written must see the new byte,
  // checked from the ports and the isRot/isRotL/isRotR decode alone so the bypass itself is not trusted
  sequence s_rot_chain;
    isRot && fileWr.en && fileWr.addr == req.fileAddr;
  endsequence

  a_rotl_bypass: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_rot_chain ##0 isRotL |=> carry == $past(fileWr.data[7])
      && (fileWr.en ? fileWr.data : acc) == {$past(fileWr.data[6:0]), $past(carry)})
    else $error("chained rotate left used a stale register");

  a_rotr_bypass: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_rot_chain ##0 isRotR |=> carry == $past(fileWr.data[0])
      && (fileWr.en ? fileWr.data : acc) == {$past(carry), $past(fileWr.data[7:1])})
    else $error("chained rotate right used a stale register");

  a_busy_refuse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    busy |=> !stackPop && !pcLoad && !fileWr.en && $stable(carry) && $stable(acc))
    else $error("request taken during return bubble");

  a_rot_no_pop: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isRot |=> !stackPop && !pcLoad && $stable(pcNext))
    else $error("rotate disturbed program counter");

  a_carry_only_rot: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !isRot |=> $stable(carry))
    else $error("carry moved without a rotate");

  a_pc_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !isRet |=> $stable(pcNext) && !stackPop)
    else $error("program counter moved without a return");

  a_pop_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
    stackPop |=> !stackPop)
    else $error("stack popped twice for one return");

endmodule // return_literal_and_carry_rotate_exec
`default_nettype wire

/* bench/file_stack_model.sv */
`timescale 1ns/1ps
`default_nettype none
module file_stack_model
  import rlc_exec_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [6:0]  fileRdAddr,
  input  wire file_wr_t    fileWr,
  input  wire logic        stackPop,
  output var  logic [7:0]  fileRdData,
  output var  logic [14:0] stackTop
);
  logic [7:0] mem [128];
  // seeded contents so every read is defined
  initial begin
    foreach (mem[i]) mem[i] = 8'(i * 37 + 5);
    stackTop = 15'h1a5c;
  end
  assign fileRdData = mem[fileRdAddr]; // same-cycle read
  // write port; top entry moves on every pop so stale values show
  always @(posedge clk_sys) begin
    if (fileWr.en) mem[fileWr.addr] <= fileWr.data;
    if (stackPop) stackTop <= stackTop + 15'h0123;
  end
endmodule // file_stack_model
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import rlc_exec_pkg::*;
;
  logic        clk_sys, reset_n, reqValid, carry, stackPop, pcLoad, busy, expC;
  exec_req_t   req;
  file_wr_t    fileWr;
  logic [7:0]  fileRdData, acc, expAcc;
  logic [7:0]  shadow [128];
  logic [6:0]  fileRdAddr;
  logic [14:0] stackTop, pcNext, expPc;
  integer      seed = 32'h6699f0fe;
  int          nErrors, checkCount, cycles;

  return_literal_and_carry_rotate_exec uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reqValid(reqValid), .req(req), .fileRdData(fileRdData), .stackTop(stackTop),
    .fileRdAddr(fileRdAddr), .fileWr(fileWr), .acc(acc), .carry(carry),
    .stackPop(stackPop), .pcLoad(pcLoad), .pcNext(pcNext), .busy(busy));
  file_stack_model partner (.clk_sys(clk_sys), .fileRdAddr(fileRdAddr), .fileWr(fileWr),
    .stackPop(stackPop), .fileRdData(fileRdData), .stackTop(stackTop));

  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (nErrors == 0 && checkCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // {carry out, result} of a one-bit rotate through carry
  function automatic logic [8:0] rot(input logic l, input logic [7:0] v, input logic c);
    return l ? {v, c} : {v[0], c, v[7:1]};
  endfunction

  // issue one request, held until the next edge takes it, then check
  task automatic step(input exec_op_t o, input logic [7:0] k, input logic [6:0] a,
                      input logic d);
    logic [8:0]  x;
    logic [14:0] stack_top;
    req = '{o, k, a, d};
    reqValid = (o != OP_NONE) | k[0]; // idle cycles both with and without valid
    x = rot(o == OP_ROT_LEFT, shadow[a], expC);
    @(posedge clk_sys);
    stack_top = stackTop;
    #1;
    if (o == OP_RET_IMM) begin
      expAcc = k;
      expPc = stack_top;
      chk(acc, k);
      chk({stackPop, pcLoad, pcNext, carry}, {2'b11, stack_top, expC});
      chk({busy, fileWr.en}, 2'b10);
      // a rotate during the bubble must be ignored
      req = '{OP_ROT_LEFT, k, a, 1'b1};
      @(posedge clk_sys);
      #1;
      chk({busy, stackPop, pcLoad, fileWr.en, carry, acc}, {4'h0, expC, k});
    end else if (o != OP_NONE) begin
      expC = x[8];
      if (!d) expAcc = x[7:0];
      if (d) shadow[a] = x[7:0];
      chk(fileRdAddr, a);
      chk(carry, expC);
      chk(acc, expAcc);
      chk(fileWr.en, d);
      if (d) chk({fileWr.addr, fileWr.data}, {a, x[7:0]});
      chk({busy, stackPop, pcLoad, pcNext}, {3'h0, expPc});
    end else begin
      chk({fileWr.en, stackPop, pcLoad, busy}, 4'h0);
      chk({pcNext, carry, acc}, {expPc, expC, expAcc});
    end
  endtask

  // hang guard, run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      end_of_test;
    end
  end

  initial begin
    reset_n = 0;
    reqValid = 0;
    req = '0;
    expAcc = 8'h00;
    expC = 1'b0;
    expPc = 15'h0000;
    // mirror of the partner's seeded register contents
    foreach (shadow[i]) shadow[i] = 8'(i * 37 + 5);
    repeat (10) @(posedge clk_sys);
    #1;
    chk({acc, carry, busy, stackPop, pcLoad, fileWr.en}, 0);
    reset_n = 1;
    // boundary literals and addresses, back-to-back chained rotates
    step(OP_RET_IMM, 8'hff, 7'h00, 1'b0);
    step(OP_ROT_LEFT, 8'h00, 7'h7f, 1'b1);
    step(OP_ROT_RIGHT, 8'h00, 7'h7f, 1'b1);
    step(OP_ROT_LEFT, 8'h00, 7'h7f, 1'b0); // reads the byte just written
    step(OP_ROT_RIGHT, 8'h00, 7'h00, 1'b0);
    step(OP_RET_IMM, 8'h00, 7'h7f, 1'b1);
    for (int i = 0; i < 300; i++)
      step(exec_op_t'(2'($random(seed))), 8'($random(seed)), 7'($random(seed)),
           1'($random(seed)));
    // reset again mid-run, after a quiet step lets the last write land
    step(OP_NONE, 8'h01, 7'h00, 1'b0);
    reset_n = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({acc, carry, busy, stackPop, pcLoad, fileWr.en, pcNext}, 0);
    expAcc = 8'h00;
    expC = 1'b0;
    expPc = 15'h0000;
    reset_n = 1;
    step(OP_ROT_LEFT, 8'h00, 7'h7f, 1'b0);
    step(OP_RET_IMM, 8'h5a, 7'h7f, 1'b0);
    reqValid = 0;
    end_of_test;
  end
endmodule // tb
`default_nettype wire
